//--- verification/ctsd_asserts.sv
// Port-level checker for the scan and detect top, bound into every instance.
// Assumes the single ref_clk_i domain and active-low async reset.
`timescale 1ns/1ps
`default_nettype none
module ctsd_asserts (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic cpu_scan_start_i,
    input wire logic conv_done_i,
    input wire logic [ctsd_pkg::PW-1:0] wake_pin_i,
    input wire logic [1:0] comm_mode_i,
    input wire logic conv_start_o,
    input wire logic [ctsd_pkg::PINS-1:0] pin_sel_o,
    input wire logic cpu_wake_o,
    input wire logic mode_wake_o,
    input wire logic [ctsd_pkg::PINS-1:0] prox_o,
    input wire logic uart_en_o,
    input wire logic i2c_en_o,
    input wire logic i2c_tune_o,
    input wire logic [6:0] i2c_addr_o,
    input wire logic [15:0] uart_div_o,
    input wire logic [15:0] i2c_min_scl_o
);
    import ctsd_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    pin_onehot_a: assert property ($onehot0(pin_sel_o)) else $error("pin select not one-hot");
    start_pulse_a: assert property (conv_start_o |-> $onehot(pin_sel_o) ##1 !conv_start_o)
        else $error("conversion start malformed");
    next_pin_a: assert property (conv_done_i && !mode_wake_o && pin_sel_o inside {4'h1, 4'h2, 4'h4}
        |=> conv_start_o && pin_sel_o == ($past(pin_sel_o) << 1)) else $error("pin order wrong");
    scan_end_a: assert property (conv_done_i && !mode_wake_o && pin_sel_o == 4'h8
        |=> pin_sel_o == 4'h0) else $error("scan did not end after last pin");
    scan_start_a: assert property (cpu_scan_start_i && !mode_wake_o && pin_sel_o == 4'h0
        && !conv_start_o |=> conv_start_o && pin_sel_o == 4'h1) else $error("scan start not taken");
    wake_pin_a: assert property (mode_wake_o && conv_start_o |-> pin_sel_o == (4'h1 << wake_pin_i))
        else $error("wake mode scanned another pin");
    prox_exit_a: assert property (mode_wake_o && conv_done_i && prox_o[wake_pin_i]
        |=> !mode_wake_o) else $error("proximity did not leave wake mode");
    wake_cpu_a: assert property ($fell(mode_wake_o) |-> ##[0:1] cpu_wake_o)
        else $error("no processor wake on leaving wake mode");
    link_none_a: assert property (rst_n_i && comm_mode_i == 2'h3
        |=> !uart_en_o && !i2c_en_o && !i2c_tune_o) else $error("link not disabled");
    link_uart_a: assert property (rst_n_i && comm_mode_i == 2'h0
        |=> uart_en_o && !i2c_en_o) else $error("uart link not selected");
    link_i2c_a: assert property (rst_n_i && comm_mode_i inside {2'h1, 2'h2}
        |=> i2c_en_o && !uart_en_o && i2c_tune_o == ($past(comm_mode_i) == 2'h1))
        else $error("i2c link selection wrong");
    link_const_a: assert property (i2c_addr_o == 7'h0A && uart_div_o == 16'h0050
        && i2c_min_scl_o == 16'h0032) else $error("link defaults wrong");
    wake_scan_c: cover property (mode_wake_o && conv_start_o);
endmodule // ctsd_asserts
bind ctsd_top ctsd_asserts u_ctsd_asserts (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .cpu_scan_start_i(cpu_scan_start_i), .conv_done_i(conv_done_i), .wake_pin_i(wake_pin_i),
    .comm_mode_i(comm_mode_i), .conv_start_o(conv_start_o), .pin_sel_o(pin_sel_o),
    .cpu_wake_o(cpu_wake_o), .mode_wake_o(mode_wake_o), .prox_o(prox_o), .uart_en_o(uart_en_o),
    .i2c_en_o(i2c_en_o), .i2c_tune_o(i2c_tune_o), .i2c_addr_o(i2c_addr_o),
    .uart_div_o(uart_div_o), .i2c_min_scl_o(i2c_min_scl_o));
`default_nettype wire

//--- verification/ctsd_conv_model.sv
// Behavioural converter and electrodes: one result per conversion start.
// Assumes pin_sel_i is one-hot while conv_start_i is high.
`timescale 1ns/1ps
`default_nettype none
module ctsd_conv_model (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic conv_start_i,
    input wire logic [3:0] pin_sel_i,
    input wire logic [15:0] raw_i [4],
    input wire logic slow_i,
    output logic conv_done_o,
    output logic [15:0] conv_count_o,
    output logic [15:0] n_start_o
);
    logic busy_reg;
    logic [3:0] wait_reg;
    logic [1:0] pin_reg;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_reg <= 1'b0;
            wait_reg <= 4'h0;
            pin_reg <= 2'h0;
            conv_done_o <= 1'b0;
            conv_count_o <= 16'h0000;
            n_start_o <= 16'h0000;
        end else begin
            conv_done_o <= 1'b0;
            // Bus inverts every cycle between results, so a late read sees the complement on alternate cycles
            conv_count_o <= ~conv_count_o;
            if (conv_start_i) begin
                busy_reg <= 1'b1;
                wait_reg <= slow_i ? 4'h6 : 4'h1;
                n_start_o <= n_start_o + 16'h0001;
                for (int i = 0; i < 4; i++) if (pin_sel_i[i]) pin_reg <= 2'(i);
            end else if (busy_reg && wait_reg == 4'h0) begin
                busy_reg <= 1'b0;
                conv_done_o <= 1'b1;
                conv_count_o <= raw_i[pin_reg];
            end else if (busy_reg) begin
                wait_reg <= wait_reg - 4'h1;
            end
        end
    end
endmodule // ctsd_conv_model
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench: random scans, detection model, mode and link checks.
// Assumes the converter model as far side and a shortened 1 ms tick.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ctsd_pkg::*;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, cpu_scan_start_i = 1'b0, mutual_i = 1'b0, slow = 1'b0;
    logic conv_done_i, conv_start_o, cpu_wake_o, mode_wake_o, fault_o, uart_en_o, i2c_en_o;
    logic i2c_tune_o;
    logic [CW-1:0] conv_count_i;
    logic [TW-1:0] active_period_i = 16'h0001, wake_period_i = 16'h0001, forced_wake_i = 16'hFFFF;
    logic [TW-1:0] idle_limit_i = 16'h03E8, near_limit_i = 16'hFFFF;
    logic [PW-1:0] wake_pin_i = 2'h0;
    logic [CW-1:0] target_count_i = 16'h03E8, fault_level_i = 16'h04B0, neg_level_i = 16'h0032;
    logic [CW-1:0] prox_level_i = 16'h0014;
    logic [7:0] touch_level_i = 8'h08, db_in_i = 8'h01, db_out_i = 8'h01;
    logic [1:0] comm_mode_i = 2'h0;
    logic [CW-1:0] raw [PINS];
    logic [PINS-1:0] pin_sel_o, prox_o, touch_o, recal_pend_o, pend = 4'hF;
    logic signed [DW-1:0] delta_o;
    logic [6:0] i2c_addr_o;
    logic [15:0] uart_div_o, i2c_min_scl_o, n_start;
    logic done_q = 1'b0;
    int n_mismatch = 0, compares = 0, cyc = 0, pin_q, raw_q, off[PINS], filt[PINS], base[PINS];
    ctsd_top #(.TICK_CYCLES(20)) u_ctsd_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .cpu_scan_start_i(cpu_scan_start_i), .conv_done_i(conv_done_i),
        .conv_count_i(conv_count_i), .active_period_i(active_period_i),
        .wake_period_i(wake_period_i), .forced_wake_i(forced_wake_i), .idle_limit_i(idle_limit_i),
        .wake_pin_i(wake_pin_i), .mutual_i(mutual_i), .target_count_i(target_count_i),
        .fault_level_i(fault_level_i), .prox_level_i(prox_level_i), .touch_level_i(touch_level_i),
        .neg_level_i(neg_level_i), .db_in_i(db_in_i), .db_out_i(db_out_i),
        .near_limit_i(near_limit_i), .comm_mode_i(comm_mode_i), .conv_start_o(conv_start_o),
        .pin_sel_o(pin_sel_o), .cpu_wake_o(cpu_wake_o), .mode_wake_o(mode_wake_o),
        .prox_o(prox_o), .touch_o(touch_o), .fault_o(fault_o), .delta_o(delta_o),
        .recal_pend_o(recal_pend_o), .uart_en_o(uart_en_o), .i2c_en_o(i2c_en_o),
        .i2c_tune_o(i2c_tune_o), .i2c_addr_o(i2c_addr_o), .uart_div_o(uart_div_o),
        .i2c_min_scl_o(i2c_min_scl_o));
    ctsd_conv_model u_ctsd_conv_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .conv_start_i(conv_start_o), .pin_sel_i(pin_sel_o), .raw_i(raw), .slow_i(slow),
        .conv_done_o(conv_done_i), .conv_count_o(conv_count_i), .n_start_o(n_start));
    initial forever #25 ref_clk_i = ~ref_clk_i;
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic int iir(int a, int b, int sh);
        return a + ((b - a) >>> sh);
    endfunction
    task automatic sample(int p, int r);
        int d, m, c, tg;
        logic pr, tc;
        tg = int'(target_count_i);
        d = 0;
        pr = 1'b0;
        tc = 1'b0;
        if (pend[p]) begin
            off[p] = tg - r;
            filt[p] = tg;
            base[p] = tg;
            pend[p] = 1'b0;
            c = tg;
        end else begin
            c = r + off[p];
            filt[p] = iir(filt[p], c, FILT_STR);
            d = filt[p] - base[p];
            m = d < 0 ? -d : d;
            pr = m >= int'(prox_level_i);
            tc = m * 128 >= base[p] * int'(touch_level_i);
            if (!pr) base[p] = iir(base[p], filt[p], BASE_STR);
            if ((mutual_i ? d > 0 : d < 0) && m >= int'(neg_level_i)) pend[p] = 1'b1;
        end
        check("delta", 32'(delta_o), 32'(d));
        check("prox", prox_o[p], pr);
        check("touch", touch_o[p], tc);
        check("fault", fault_o, c > int'(fault_level_i));
        check("recal", recal_pend_o[p], pend[p]);
    endtask
    always @(posedge ref_clk_i) begin
        done_q <= conv_done_i;
        raw_q <= int'(conv_count_i);
        for (int i = 0; i < PINS; i++) if (pin_sel_o[i]) pin_q <= i;
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    always @(negedge ref_clk_i) if (done_q) sample(pin_q, raw_q);
    task automatic scan();
        int t;
        t = 0;
        @(posedge ref_clk_i) cpu_scan_start_i <= 1'b1;
        @(posedge ref_clk_i) cpu_scan_start_i <= 1'b0;
        // Second start lands mid-scan and must be ignored
        repeat (3) @(posedge ref_clk_i);
        cpu_scan_start_i <= 1'b1;
        @(posedge ref_clk_i) cpu_scan_start_i <= 1'b0;
        while (pin_sel_o !== 4'h0 && t < 200) begin
            @(posedge ref_clk_i);
            t++;
        end
        check("scan_done", t < 200, 1'b1);
        repeat (2) @(posedge ref_clk_i);
    endtask
    task automatic wait_mode(logic v, int lim);
        int t;
        t = 0;
        while (mode_wake_o !== v && t < lim) begin
            @(posedge ref_clk_i);
            t++;
        end
    endtask
    task automatic clean_scans();
        // Aim at each baseline so a frozen baseline cannot keep proximity set
        for (int p = 0; p < PINS; p++) raw[p] <= 16'(base[p] - off[p]);
        repeat (4) scan();
    endtask
    initial begin
        int k, n, wp;
        void'($urandom(24103));
        for (int p = 0; p < PINS; p++) raw[p] = 16'h0384;
        repeat (20) @(posedge ref_clk_i);
        check("recal_rst", recal_pend_o, 4'hF);
        check("mode_rst", mode_wake_o, 1'b0);
        check("i2c_addr_rst", i2c_addr_o, 7'h0A);
        check("link_div_rst", {uart_div_o, i2c_min_scl_o}, {16'h0050, 16'h0032});
        rst_n_i <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            comm_mode_i <= 2'(m);
            repeat (2) @(posedge ref_clk_i);
            check("link", {uart_en_o, i2c_en_o, i2c_tune_o}, {m == 0, m == 1 || m == 2, m == 1});
        end
        for (int s = 0; s < 40; s++) begin
            @(posedge ref_clk_i);
            mutual_i <= (s >= 20);
            slow <= 1'($urandom % 2);
            for (int p = 0; p < PINS; p++) begin
                k = int'($urandom % 8);
                raw[p] <= 16'(900 + int'($urandom % 60) + (k < 2 ? 150 : (k == 2 ? -120 : 0)));
            end
            scan();
        end
        check("starts", n_start, 16'h00A0);
        mutual_i <= 1'b0;
        clean_scans();
        n = 0;
        repeat (200) @(posedge ref_clk_i) if (cpu_wake_o === 1'b1) n++;
        check("wake_rate", n >= 9 && n <= 11, 1'b1);
        wp = int'($urandom % 4);
        wake_pin_i <= 2'(wp);
        idle_limit_i <= 16'h0002;
        wait_mode(1'b1, 200);
        check("enter_wake", mode_wake_o, 1'b1);
        repeat (30) @(posedge ref_clk_i);
        raw[wp] <= 16'(1100 - off[wp]);
        wait_mode(1'b0, 300);
        check("prox_wake", mode_wake_o, 1'b0);
        clean_scans();
        forced_wake_i <= 16'h0003;
        wait_mode(1'b1, 300);
        wait_mode(1'b0, 400);
        @(negedge ref_clk_i);
        check("forced_recal", {mode_wake_o, recal_pend_o}, 5'h0F);
        pend = 4'hF;
        wait_mode(1'b1, 200);
        check("reenter_wake", mode_wake_o, 1'b1);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire

//--- verilog/ctsd_pkg.sv
// Shared constants and types of the capacitive touch scan and detect block.
// Assumes a 20 MHz single clock domain and one measurement block of four pins.
package ctsd_pkg;
    localparam int PINS = 4;
    localparam int PW = 2;
    localparam int CW = 16;
    localparam int DW = 18;
    localparam int TW = 16;
    localparam int CLK_NS = 50;
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_NS = 1_000_000;
    localparam int TICK_DIV = MS_NS / CLK_NS;
    localparam int FILT_STR = 1;
    localparam int BASE_STR = 7;
    localparam int TOUCH_SH = 7;
    localparam int UART_BAUD = 250_000;
    localparam logic [15:0] UART_DIV = 16'(CLK_HZ / UART_BAUD);
    localparam int I2C_MAX_HZ = 400_000;
    localparam logic [15:0] I2C_MIN_SCL = 16'(CLK_HZ / I2C_MAX_HZ);
    localparam logic [6:0] I2C_ADDR = 7'h0A;
    localparam logic [TW-1:0] CNT_RST = 16'h0000;

    typedef enum logic [1:0] {
        COMM_UART = 2'h0,
        COMM_I2C_TUNE = 2'h1,
        COMM_I2C_REG = 2'h2,
        COMM_NONE = 2'h3
    } ctsd_comm_t;

    typedef enum logic [1:0] {
        MODE_ACTIVE = 2'h1,
        MODE_WAKE = 2'h2
    } ctsd_mode_t;

    typedef enum logic [1:0] {
        SC_IDLE = 2'h1,
        SC_WAIT = 2'h2
    } ctsd_scan_t;
endpackage

//--- verilog/ctsd_timer.sv
// Period timer counting millisecond ticks; one-cycle expire pulse each period.
// Assumes tick is a one-cycle enable on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ctsd_timer (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    ctsd_tmr_if.timer t
);
    import ctsd_pkg::*;
    logic [TW-1:0] cnt_reg;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= CNT_RST;
            t.expire <= 1'b0;
        end else if (t.restart) begin
            cnt_reg <= CNT_RST;
            t.expire <= 1'b0;
        end else if (t.tick) begin
            // A zero period behaves as one tick
            if (cnt_reg + 16'h0001 >= t.period) begin
                cnt_reg <= CNT_RST;
                t.expire <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 16'h0001;
                t.expire <= 1'b0;
            end
        end else begin
            t.expire <= 1'b0;
        end
    end
endmodule // ctsd_timer
`default_nettype wire

//--- verilog/ctsd_tmr_if.sv
// Carrier between the sequencer and one of its period timers.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ctsd_tmr_if;
    logic tick;
    logic restart;
    logic [15:0] period;
    logic expire;
    modport owner(output tick, output restart, output period, input expire);
    modport timer(input tick, input restart, input period, output expire);
endinterface
`default_nettype wire

//--- verilog/ctsd_top.sv
// Scan sequencer, mode control and detection for one four-pin measurement block.
// Assumes converter and processor handshakes come from logic on ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module ctsd_top #(
    parameter int TICK_CYCLES = ctsd_pkg::TICK_DIV
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic cpu_scan_start_i,
    input wire logic conv_done_i,
    input wire logic [ctsd_pkg::CW-1:0] conv_count_i,
    input wire logic [ctsd_pkg::TW-1:0] active_period_i,
    input wire logic [ctsd_pkg::TW-1:0] wake_period_i,
    input wire logic [ctsd_pkg::TW-1:0] forced_wake_i,
    input wire logic [ctsd_pkg::TW-1:0] idle_limit_i,
    input wire logic [ctsd_pkg::PW-1:0] wake_pin_i,
    input wire logic mutual_i,
    input wire logic [ctsd_pkg::CW-1:0] target_count_i,
    input wire logic [ctsd_pkg::CW-1:0] fault_level_i,
    input wire logic [ctsd_pkg::CW-1:0] prox_level_i,
    input wire logic [7:0] touch_level_i,
    input wire logic [ctsd_pkg::CW-1:0] neg_level_i,
    input wire logic [7:0] db_in_i,
    input wire logic [7:0] db_out_i,
    input wire logic [ctsd_pkg::TW-1:0] near_limit_i,
    input wire logic [1:0] comm_mode_i,
    output logic conv_start_o,
    output logic [ctsd_pkg::PINS-1:0] pin_sel_o,
    output logic cpu_wake_o,
    output logic mode_wake_o,
    output logic [ctsd_pkg::PINS-1:0] prox_o,
    output logic [ctsd_pkg::PINS-1:0] touch_o,
    output logic fault_o,
    output logic signed [ctsd_pkg::DW-1:0] delta_o,
    output logic [ctsd_pkg::PINS-1:0] recal_pend_o,
    output logic uart_en_o,
    output logic i2c_en_o,
    output logic i2c_tune_o,
    output logic [6:0] i2c_addr_o,
    output logic [15:0] uart_div_o,
    output logic [15:0] i2c_min_scl_o
);
    import ctsd_pkg::*;

    ctsd_mode_t mode_reg;
    ctsd_scan_t scan_reg;
    logic [31:0] div_reg;
    logic tick_reg;
    logic [PW-1:0] idx_reg;
    logic [TW-1:0] idle_reg;
    logic signed [DW-1:0] offs_reg [PINS];
    logic signed [DW-1:0] filt_reg [PINS];
    logic signed [DW-1:0] base_reg [PINS];
    logic [7:0] pcnt_reg [PINS];
    logic [7:0] tcnt_reg [PINS];
    logic [TW-1:0] near_reg [PINS];
    logic [PINS-1:0] cal_reg;

    ctsd_tmr_if act_t ();
    ctsd_tmr_if wak_t ();
    ctsd_tmr_if frc_t ();

    ctsd_timer u_act (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .t(act_t.timer));
    ctsd_timer u_wak (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .t(wak_t.timer));
    ctsd_timer u_frc (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .t(frc_t.timer));

    assign act_t.tick = tick_reg;
    assign act_t.restart = (mode_reg != MODE_ACTIVE);
    assign act_t.period = active_period_i;
    assign wak_t.tick = tick_reg;
    assign wak_t.restart = (mode_reg != MODE_WAKE);
    assign wak_t.period = wake_period_i;
    assign frc_t.tick = tick_reg;
    assign frc_t.restart = (mode_reg != MODE_WAKE);
    assign frc_t.period = forced_wake_i;

    // Millisecond enable; the divide is a parameter so simulation can shorten it
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else if (div_reg + 32'h0000_0001 >= 32'(TICK_CYCLES)) begin
            div_reg <= 32'h0000_0000;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 32'h0000_0001;
            tick_reg <= 1'b0;
        end
    end

    // Sample path for the pin just converted
    logic signed [DW-1:0] corr, nf, nb, delta, sdelta, mag, target;
    logic [25:0] mag_sc, touch_sc;
    logic fault_hit, prox_hit, touch_hit, neg_hit, freeze;

    always_comb begin
        target = DW'(signed'({1'b0, target_count_i}));
        // A calibrating sample reads as the target, so fault and difference see no stale offset
        corr = cal_reg[idx_reg] ? target
                                : DW'(signed'({1'b0, conv_count_i})) + offs_reg[idx_reg];
        fault_hit = corr > DW'(signed'({1'b0, fault_level_i}));
        nf = filt_reg[idx_reg] + ((corr - filt_reg[idx_reg]) >>> FILT_STR);
        delta = cal_reg[idx_reg] ? '0 : nf - base_reg[idx_reg];
        sdelta = mutual_i ? -delta : delta;
        mag = (delta < 0) ? -delta : delta;
        prox_hit = mag >= DW'(signed'({1'b0, prox_level_i}));
        freeze = prox_hit;
        nb = freeze ? base_reg[idx_reg]
                    : base_reg[idx_reg] + ((nf - base_reg[idx_reg]) >>> BASE_STR);
        mag_sc = {1'b0, mag[DW-2:0], 8'h00} >> 1;
        touch_sc = 26'(base_reg[idx_reg][DW-2:0]) * 26'(touch_level_i);
        touch_hit = mag_sc >= touch_sc;
        neg_hit = (sdelta < 0) && (-sdelta >= DW'(signed'({1'b0, neg_level_i})));
    end

    wire sample = (scan_reg == SC_WAIT) && conv_done_i;
    wire wake_hit = sample && (mode_reg == MODE_WAKE) && (prox_o[idx_reg] | fault_hit);
    wire force_cal = (mode_reg == MODE_WAKE) && frc_t.expire;
    wire any_det = (|prox_o) | (|touch_o);

    // Debounced flag step: returns {flag, count}
    function automatic logic [8:0] debounce(input logic flag, input logic hit,
                                            input logic [7:0] cnt);
        logic [7:0] n;
        n = cnt + 8'h01;
        if (hit != flag) begin
            if (n >= (flag ? db_out_i : db_in_i))
                debounce = {hit, 8'h00};
            else
                debounce = {flag, n};
        end else begin
            debounce = {flag, 8'h00};
        end
    endfunction

    // Mode sequencing
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_reg <= MODE_ACTIVE;
            idle_reg <= CNT_RST;
            cpu_wake_o <= 1'b0;
        end else begin
            cpu_wake_o <= 1'b0;
            unique case (mode_reg)
                MODE_ACTIVE: begin
                    if (act_t.expire) begin
                        cpu_wake_o <= 1'b1;
                    end
                    if (any_det) begin
                        idle_reg <= CNT_RST;
                    end else if (act_t.expire) begin
                        if (idle_reg + 16'h0001 < idle_limit_i) begin
                            idle_reg <= idle_reg + 16'h0001;
                        end else if (scan_reg == SC_IDLE && !cpu_scan_start_i) begin
                            // Only between scans, so an active scan is never cut short
                            idle_reg <= CNT_RST;
                            mode_reg <= MODE_WAKE;
                        end
                    end
                end
                MODE_WAKE: begin
                    if (wake_hit || force_cal) begin
                        mode_reg <= MODE_ACTIVE;
                        cpu_wake_o <= 1'b1;
                        idle_reg <= CNT_RST;
                    end
                end
            endcase
        end
    end
    assign mode_wake_o = mode_reg[1];

    // Scan sequencer: one pin at a time
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scan_reg <= SC_IDLE;
            idx_reg <= 2'h0;
            conv_start_o <= 1'b0;
            pin_sel_o <= 4'h0;
        end else begin
            conv_start_o <= 1'b0;
            unique case (scan_reg)
                SC_IDLE: begin
                    if (mode_reg == MODE_ACTIVE && cpu_scan_start_i) begin
                        idx_reg <= 2'h0;
                        pin_sel_o <= 4'h1;
                        conv_start_o <= 1'b1;
                        scan_reg <= SC_WAIT;
                    end else if (mode_reg == MODE_WAKE && wak_t.expire) begin
                        idx_reg <= wake_pin_i;
                        pin_sel_o <= 4'h1 << wake_pin_i;
                        conv_start_o <= 1'b1;
                        scan_reg <= SC_WAIT;
                    end
                end
                SC_WAIT: begin
                    if (conv_done_i) begin
                        if (mode_reg == MODE_ACTIVE && idx_reg != 2'(PINS - 1)) begin
                            idx_reg <= idx_reg + 2'h1;
                            pin_sel_o <= pin_sel_o << 1;
                            conv_start_o <= 1'b1;
                        end else begin
                            pin_sel_o <= 4'h0;
                            scan_reg <= SC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Per-pin filter, calibration and detection state
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            wire mine = sample && (idx_reg == PW'(g));
            logic [8:0] pd, td;
            assign pd = debounce(prox_o[g], prox_hit, pcnt_reg[g]);
            assign td = debounce(touch_o[g], touch_hit, tcnt_reg[g]);
            wire near_full = prox_o[g] && (near_reg[g] + 16'h0001 >= near_limit_i);

            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    offs_reg[g] <= '0;
                    filt_reg[g] <= '0;
                    base_reg[g] <= '0;
                end else if (mine && cal_reg[g]) begin
                    offs_reg[g] <= target - DW'(signed'({1'b0, conv_count_i}));
                    filt_reg[g] <= target;
                    base_reg[g] <= target;
                end else if (mine) begin
                    filt_reg[g] <= nf;
                    base_reg[g] <= nb;
                end
            end

            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    prox_o[g] <= 1'b0;
                    touch_o[g] <= 1'b0;
                    pcnt_reg[g] <= 8'h00;
                    tcnt_reg[g] <= 8'h00;
                    near_reg[g] <= CNT_RST;
                end else if (mine && cal_reg[g]) begin
                    prox_o[g] <= 1'b0;
                    touch_o[g] <= 1'b0;
                    pcnt_reg[g] <= 8'h00;
                    tcnt_reg[g] <= 8'h00;
                    near_reg[g] <= CNT_RST;
                end else if (mine) begin
                    {prox_o[g], pcnt_reg[g]} <= pd;
                    {touch_o[g], tcnt_reg[g]} <= td;
                    if (!prox_o[g] || near_full)
                        near_reg[g] <= CNT_RST;
                    else
                        near_reg[g] <= near_reg[g] + 16'h0001;
                end
            end

            // Request wins over the clear of the same cycle
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cal_reg[g] <= 1'b1;
                end else if (force_cal) begin
                    cal_reg[g] <= 1'b1;
                end else if (mine && !cal_reg[g] && (neg_hit || near_full)) begin
                    cal_reg[g] <= 1'b1;
                end else if (mine) begin
                    cal_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate
    assign recal_pend_o = cal_reg;

    // Last sample status
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_o <= 1'b0;
            delta_o <= '0;
        end else if (sample) begin
            fault_o <= fault_hit;
            delta_o <= delta;
        end
    end

    // Host link selection; none turns every link off
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            uart_en_o <= 1'b0;
            i2c_en_o <= 1'b0;
            i2c_tune_o <= 1'b0;
            i2c_addr_o <= I2C_ADDR;
            uart_div_o <= UART_DIV;
            i2c_min_scl_o <= I2C_MIN_SCL;
        end else begin
            uart_en_o <= (comm_mode_i == COMM_UART);
            i2c_en_o <= (comm_mode_i == COMM_I2C_TUNE) || (comm_mode_i == COMM_I2C_REG);
            i2c_tune_o <= (comm_mode_i == COMM_I2C_TUNE);
            i2c_addr_o <= I2C_ADDR;
            uart_div_o <= UART_DIV;
            i2c_min_scl_o <= I2C_MIN_SCL;
        end
    end
endmodule // ctsd_top
`default_nettype wire
